// [verilog/uart_baud_map.svh]
`ifndef UART_BAUD_MAP_SVH
`define UART_BAUD_MAP_SVH

// ----------------
// Timer prescale and baud division
// ----------------
`define TIMER_A_SLOW_DIV     4'hc
`define TIMER_A_FAST_STEP    4'h8
`define WIDE_TIMER_DIV       1'h1
`define TIMER_A_MAX          8'hff
`define WIDE_TIMER_MAX       16'hffff
`define BAUD_DIV_LAST        4'hf

// ----------------
// Receive sampling points inside one bit
// ----------------
`define RX_SAMPLE_FIRST      4'h7
`define RX_SAMPLE_LAST       4'h9
`define RX_DATA_LAST_INDEX   3'h7

// ----------------
// Transmit frame and flag timing
// ----------------
`define TX_FRAME_BITS        4'ha
`define TX_DONE_DELAY        2'h2

// ----------------
// Reset values
// ----------------
`define SERIAL_IDLE_LEVEL    1'h1
`define BYTE_RESET           8'h00

`endif

// [verilog/uart_baud_pkg.sv]
package uart_baud_pkg;

    // Gray order along the usual receive path
    typedef enum logic [1:0] {
        RX_IDLE  = 2'h0,
        RX_START = 2'h1,
        RX_DATA  = 2'h3,
        RX_STOP  = 2'h2
    } rx_state_t;

    typedef logic [7:0] byte_t;

endpackage

// [verilog/serial_port_if.sv]
`timescale 1ns/10ps
interface serial_port_if;
    logic                    tx_tick;
    logic                    rx_tick;
    logic                    buffer_write;
    uart_baud_pkg::byte_t    write_data;
    logic                    rx_enable;
    logic                    multiproc_enable;
    logic                    tx_done_clear;
    logic                    rx_done_clear;
    uart_baud_pkg::byte_t    rx_byte;
    logic                    extra_bit;
    logic                    tx_done;
    logic                    rx_done;

    modport ctrl (
        output tx_tick, rx_tick, buffer_write, write_data, rx_enable,
               multiproc_enable, tx_done_clear, rx_done_clear,
        input  rx_byte, extra_bit, tx_done, rx_done
    );
    modport port (
        input  tx_tick, rx_tick, buffer_write, write_data, rx_enable,
               multiproc_enable, tx_done_clear, rx_done_clear,
        output rx_byte, extra_bit, tx_done, rx_done
    );
endinterface

// [verilog/serial_port.sv]
`timescale 1ns/10ps
`include "uart_baud_map.svh"
module serial_port (
    input  wire logic   clk,
    input  wire logic   rst_n,
    input  wire logic   ce,
    input  wire logic   serial_in_pin,
    output logic        serial_out_pin,
    serial_port_if.port sp
);
    // ----------------
    // Transmitter
    // ----------------
    logic [3:0] tx_div_r;
    logic       tx_pend_r;
    logic [8:0] tx_shift_r;
    logic [3:0] tx_left_r;
    logic [1:0] tx_delay_r;
    logic       tx_roll;

    assign tx_roll = sp.tx_tick && (tx_div_r == `BAUD_DIV_LAST);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_div_r <= 4'h0;
        end else if (ce && sp.tx_tick) begin
            tx_div_r <= tx_div_r + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_pend_r      <= 1'b0;
            tx_shift_r     <= 9'h1ff;
            tx_left_r      <= 4'h0;
            serial_out_pin <= `SERIAL_IDLE_LEVEL;
            tx_delay_r     <= 2'h0;
        end else if (ce) begin
            if (sp.buffer_write) begin
                tx_pend_r  <= 1'b1;
                tx_shift_r <= {1'b1, sp.write_data};
            end
            if (tx_delay_r != 2'h0) begin
                tx_delay_r <= tx_delay_r - 2'h1;
            end
            if (tx_roll) begin
                if (tx_left_r != 4'h0) begin
                    // Ones fill in behind the stop bit; the tenth count ends it
                    serial_out_pin <= tx_shift_r[0];
                    tx_shift_r     <= {1'b1, tx_shift_r[8:1]};
                    tx_left_r      <= tx_left_r - 4'h1;
                    if (tx_left_r == 4'h1) begin
                        tx_delay_r <= `TX_DONE_DELAY;  // see [RULE10]
                    end
                end else if (tx_pend_r && !sp.buffer_write) begin
                    serial_out_pin <= 1'b0;  // see [RULE8] see [RULE9]
                    tx_pend_r      <= 1'b0;
                    tx_left_r      <= `TX_FRAME_BITS;
                end else begin
                    serial_out_pin <= `SERIAL_IDLE_LEVEL;
                end
            end
        end
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sp.tx_done <= 1'b0;
        end else if (ce) begin
            if (tx_delay_r == 2'h1) begin
                sp.tx_done <= 1'b1;  // see [RULE10]
            end else if (sp.tx_done_clear) begin
                sp.tx_done <= 1'b0;
            end
        end
    end

    // ----------------
    // Receiver
    // ----------------
    logic                     rx_meta_r;
    logic                     rx_sync_r;
    logic                     rx_prev_r;
    logic [3:0]               rx_div_r;
    logic [2:0]               rx_votes_r;
    logic [2:0]               rx_index_r;
    uart_baud_pkg::byte_t     rx_shift_r;
    uart_baud_pkg::rx_state_t rx_state_r;
    logic                     rx_decide;
    logic                     rx_bit;
    logic                     rx_accept;

    function automatic logic majority(input logic [2:0] v);
        majority = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
    endfunction

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
            rx_prev_r <= 1'b1;
        end else if (ce) begin
            rx_meta_r <= serial_in_pin;
            rx_sync_r <= rx_meta_r;
            rx_prev_r <= rx_sync_r;
        end
    end

    assign rx_decide = sp.rx_tick && (rx_div_r == `RX_SAMPLE_LAST);
    assign rx_bit    = majority({rx_votes_r[1:0], rx_sync_r});  // see [RULE13]
    assign rx_accept = !sp.rx_done && (!sp.multiproc_enable || rx_bit);  // see [RULE15]

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_div_r   <= 4'h0;
            rx_votes_r <= 3'h7;
        end else if (ce) begin
            if (rx_state_r == uart_baud_pkg::RX_IDLE) begin
                rx_div_r <= 4'h0;  // see [RULE12]
            end else if (sp.rx_tick) begin
                rx_div_r <= rx_div_r + 4'h1;
                if (rx_div_r >= `RX_SAMPLE_FIRST && rx_div_r <= `RX_SAMPLE_LAST) begin
                    rx_votes_r <= {rx_votes_r[1:0], rx_sync_r};
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_state_r <= uart_baud_pkg::RX_IDLE;
            rx_index_r <= 3'h0;
            rx_shift_r <= `BYTE_RESET;
        end else if (ce) begin
            case (rx_state_r)
                uart_baud_pkg::RX_IDLE: begin
                    if (sp.rx_enable && rx_prev_r && !rx_sync_r) begin
                        rx_state_r <= uart_baud_pkg::RX_START;  // see [RULE11]
                    end
                end
                uart_baud_pkg::RX_START: begin
                    if (rx_decide) begin
                        rx_index_r <= 3'h0;
                        rx_state_r <= rx_bit ? uart_baud_pkg::RX_IDLE  // see [RULE14]
                                             : uart_baud_pkg::RX_DATA;
                    end
                end
                uart_baud_pkg::RX_DATA: begin
                    if (rx_decide) begin
                        rx_shift_r <= {rx_bit, rx_shift_r[7:1]};
                        rx_index_r <= rx_index_r + 3'h1;
                        if (rx_index_r == `RX_DATA_LAST_INDEX) begin
                            rx_state_r <= uart_baud_pkg::RX_STOP;
                        end
                    end
                end
                uart_baud_pkg::RX_STOP: begin
                    if (rx_decide) begin
                        rx_state_r <= uart_baud_pkg::RX_IDLE;  // see [RULE17]
                    end
                end
                default: begin
                    rx_state_r <= uart_baud_pkg::RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sp.rx_byte   <= `BYTE_RESET;
            sp.extra_bit <= 1'b0;
            sp.rx_done   <= 1'b0;
        end else if (ce) begin
            if (rx_state_r == uart_baud_pkg::RX_STOP && rx_decide && rx_accept) begin
                sp.rx_byte   <= rx_shift_r;  // see [RULE16]
                sp.extra_bit <= rx_bit;
                sp.rx_done   <= 1'b1;
            end else if (sp.rx_done_clear) begin
                sp.rx_done <= 1'b0;
            end
        end
    end
endmodule

// [verilog/uart_async_mode1_baud.sv]
`timescale 1ns/10ps
`include "uart_baud_map.svh"
// Function
// [RULE1] Port 0 may use either timer for baud; port 1 only the 8-bit timer.
// [RULE2] Each timer rollover gives one baud pulse, divided by 16 per bit.
// [RULE3] Doubling bit chooses whether 8-bit timer rollovers are halved first.
// [RULE4] 8-bit rate: 2^d/32 * clock / ((12-8*sel)*(256-reload)).
// [RULE5] Transmit and receive select bits route the 16-bit timer independently.
// [RULE6] 16-bit rate: clock / (32*(65536-reload)).
// [RULE7] While routed to a port, 16-bit rollover sets no flag; trigger ignored.
// [RULE8] Transmission starts at the first divide-by-16 rollover after a write.
// [RULE9] Frame: low start bit, eight data bits LSB first, high stop bit.
// [RULE10] Transmit-done flag sets two clocks after the stop bit ends.
// [RULE11] Reception starts on a falling input edge only while enabled.
// [RULE12] Input sampled 16 times per bit; start edge realigns divider.
// [RULE13] Each bit decided by majority of three middle samples.
// [RULE14] Start bit not voted low abandons the frame.
// [RULE15] Accept frame only if receive-done clear and, in multiproc, stop is 1.
// [RULE16] Acceptance loads byte, stop bit, sets receive-done; else nothing changes.
// [RULE17] After mid stop bit the receiver waits for the next falling edge.
// [RULE18] Software should run the 8-bit timer in auto-reload mode.
// [RULE19] Software clears the done flags; hardware never does.
// [RULE20] Both ports share identical independent logic, differing only in source.
module uart_async_mode1_baud #(
    parameter int DATA_BITS = 8
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic [7:0]  timer_a_reload_byte,
    input  wire logic        timer_a_clock_select,
    input  wire logic [7:0]  wide_timer_reload_high,
    input  wire logic [7:0]  wide_timer_reload_low,
    input  wire logic        tx_wide_timer_select,
    input  wire logic        rx_wide_timer_select,
    input  wire logic        wide_timer_external_trigger,
    input  wire logic        wide_timer_overflow_clear,
    output logic             wide_timer_overflow_flag,
    input  wire logic        port0_baud_double_bit,
    input  wire logic        port1_baud_double_bit,
    input  wire logic        port0_buffer_write,
    input  wire logic [7:0]  port0_write_data,
    input  wire logic        port1_buffer_write,
    input  wire logic [7:0]  port1_write_data,
    input  wire logic        port0_rx_enable,
    input  wire logic        port1_rx_enable,
    input  wire logic        port0_multiproc_enable,
    input  wire logic        port1_multiproc_enable,
    input  wire logic        port0_tx_done_clear,
    input  wire logic        port0_rx_done_clear,
    input  wire logic        port1_tx_done_clear,
    input  wire logic        port1_rx_done_clear,
    input  wire logic        port0_serial_in_pin,
    input  wire logic        port1_serial_in_pin,
    output logic             port0_serial_out_pin,
    output logic             port1_serial_out_pin,
    output logic [7:0]       port0_serial_buffer,
    output logic [7:0]       port1_serial_buffer,
    output logic             port0_received_extra_bit,
    output logic             port1_received_extra_bit,
    output logic             port0_tx_done_flag,
    output logic             port1_tx_done_flag,
    output logic             port0_rx_done_flag,
    output logic             port1_rx_done_flag
);
    // Frame width is fixed by the shift logic
    if (DATA_BITS != 8) begin : g_bad_width
        $error("DATA_BITS must be 8");
    end

    // ----------------
    // 8-bit auto-reload timer
    // ----------------
    logic [3:0] a_pre_r;
    logic [7:0] a_cnt_r;
    logic       a_roll_r;
    logic [3:0] a_pre_last;

    // Prescale of 12 or 4 core clocks per count
    assign a_pre_last = `TIMER_A_SLOW_DIV - (timer_a_clock_select ? `TIMER_A_FAST_STEP : 4'h0) - 4'h1;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            a_pre_r  <= 4'h0;
            a_cnt_r  <= 8'h00;
            a_roll_r <= 1'b0;
        end else if (ce) begin
            a_roll_r <= 1'b0;
            if (a_pre_r >= a_pre_last) begin
                a_pre_r <= 4'h0;
                if (a_cnt_r == `TIMER_A_MAX) begin
                    a_cnt_r  <= timer_a_reload_byte;  // see [RULE4]
                    a_roll_r <= 1'b1;  // see [RULE2]
                end else begin
                    a_cnt_r <= a_cnt_r + 8'h01;
                end
            end else begin
                a_pre_r <= a_pre_r + 4'h1;
            end
        end
    end

    // ----------------
    // Per-port halving stage
    // ----------------
    logic [1:0] half_r;
    logic [1:0] a_tick;

    assign a_tick[0] = a_roll_r && (port0_baud_double_bit || half_r[0]);  // see [RULE3]
    assign a_tick[1] = a_roll_r && (port1_baud_double_bit || half_r[1]);  // see [RULE3]

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            half_r <= 2'h0;
        end else if (ce && a_roll_r) begin
            half_r <= ~half_r;
        end
    end

    // ----------------
    // 16-bit auto-reload timer
    // ----------------
    logic        w_pre_r;
    logic [15:0] w_cnt_r;
    logic        w_roll_r;
    logic        trig_meta_r;
    logic        trig_sync_r;
    logic        trig_prev_r;
    logic        w_baud_mode;
    logic [15:0] w_reload;

    assign w_baud_mode = tx_wide_timer_select || rx_wide_timer_select;
    assign w_reload    = {wide_timer_reload_high, wide_timer_reload_low};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trig_meta_r <= 1'b1;
            trig_sync_r <= 1'b1;
            trig_prev_r <= 1'b1;
        end else if (ce) begin
            trig_meta_r <= wide_timer_external_trigger;
            trig_sync_r <= trig_meta_r;
            trig_prev_r <= trig_sync_r;
        end
    end

    // Two core clocks per count give clock/32 per bit after the /16
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            w_pre_r  <= 1'b0;
            w_cnt_r  <= 16'h0000;
            w_roll_r <= 1'b0;
        end else if (ce) begin
            w_roll_r <= 1'b0;
            w_pre_r  <= w_pre_r + 1'b1;
            if (!w_baud_mode && trig_prev_r && !trig_sync_r) begin
                w_cnt_r <= w_reload;  // see [RULE7]
            end else if (w_pre_r == `WIDE_TIMER_DIV) begin
                if (w_cnt_r == `WIDE_TIMER_MAX) begin
                    w_cnt_r  <= w_reload;  // see [RULE6]
                    w_roll_r <= 1'b1;  // see [RULE2]
                end else begin
                    w_cnt_r <= w_cnt_r + 16'h0001;
                end
            end
        end
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wide_timer_overflow_flag <= 1'b0;
        end else if (ce) begin
            if (w_roll_r && !w_baud_mode) begin
                wide_timer_overflow_flag <= 1'b1;  // see [RULE7]
            end else if (wide_timer_overflow_clear) begin
                wide_timer_overflow_flag <= 1'b0;
            end
        end
    end

    // ----------------
    // Serial ports
    // ----------------
    serial_port_if p0_if ();
    serial_port_if p1_if ();

    // Only port 0 may route the wide timer
    assign p0_if.tx_tick          = tx_wide_timer_select ? w_roll_r : a_tick[0];  // see [RULE1] see [RULE5]
    assign p0_if.rx_tick          = rx_wide_timer_select ? w_roll_r : a_tick[0];  // see [RULE5]
    assign p1_if.tx_tick          = a_tick[1];  // see [RULE1]
    assign p1_if.rx_tick          = a_tick[1];
    assign p0_if.buffer_write     = port0_buffer_write;
    assign p0_if.write_data       = port0_write_data;
    assign p0_if.rx_enable        = port0_rx_enable;
    assign p0_if.multiproc_enable = port0_multiproc_enable;
    assign p0_if.tx_done_clear    = port0_tx_done_clear;
    assign p0_if.rx_done_clear    = port0_rx_done_clear;
    assign p1_if.buffer_write     = port1_buffer_write;
    assign p1_if.write_data       = port1_write_data;
    assign p1_if.rx_enable        = port1_rx_enable;
    assign p1_if.multiproc_enable = port1_multiproc_enable;
    assign p1_if.tx_done_clear    = port1_tx_done_clear;
    assign p1_if.rx_done_clear    = port1_rx_done_clear;

    // Identical independent ports
    serial_port u_port0 (  // see [RULE20]
        .clk            (clk),
        .rst_n          (rst_n),
        .ce             (ce),
        .serial_in_pin  (port0_serial_in_pin),
        .serial_out_pin (port0_serial_out_pin),
        .sp             (p0_if.port)
    );

    serial_port u_port1 (
        .clk            (clk),
        .rst_n          (rst_n),
        .ce             (ce),
        .serial_in_pin  (port1_serial_in_pin),
        .serial_out_pin (port1_serial_out_pin),
        .sp             (p1_if.port)
    );

    // Straight from the port flip-flops
    assign port0_serial_buffer      = p0_if.rx_byte;
    assign port1_serial_buffer      = p1_if.rx_byte;
    assign port0_received_extra_bit = p0_if.extra_bit;
    assign port1_received_extra_bit = p1_if.extra_bit;
    assign port0_tx_done_flag       = p0_if.tx_done;
    assign port1_tx_done_flag       = p1_if.tx_done;
    assign port0_rx_done_flag       = p0_if.rx_done;
    assign port1_rx_done_flag       = p1_if.rx_done;
endmodule

// [verif/uart_async_mode1_baud_chk.sv]
`timescale 1ns/10ps
module uart_async_mode1_baud_chk (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       tx_wide_timer_select,
    input wire logic       rx_wide_timer_select,
    input wire logic       wide_timer_overflow_flag,
    input wire logic       port0_multiproc_enable,
    input wire logic       port0_serial_out_pin,
    input wire logic       port1_serial_out_pin,
    input wire logic [7:0] port0_serial_buffer,
    input wire logic       port0_received_extra_bit,
    input wire logic       port0_tx_done_flag,
    input wire logic       port0_tx_done_clear,
    input wire logic       port0_rx_done_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----------------
    // Transmit
    // ----------------
    // Shortest bit is 32 clocks, so eight low cycles always hold
    a_start_bit_low: assert property ($fell(port0_serial_out_pin) |-> !port0_serial_out_pin [*8])
        else $error("port0 start bit too short");
    a_port1_start_low: assert property ($fell(port1_serial_out_pin) |-> !port1_serial_out_pin [*8])
        else $error("port1 start bit too short");
    a_tx_done_stop: assert property ($rose(port0_tx_done_flag) |->
        port0_serial_out_pin && $past(port0_serial_out_pin, 3))
        else $error("transmit done without stop bit");
    a_tx_done_sticky: assert property (port0_tx_done_flag && !port0_tx_done_clear
        |=> port0_tx_done_flag)
        else $error("transmit done dropped by itself");
    // ----------------
    // Receive and timer flag
    // ----------------
    a_ovf_not_routed: assert property ($rose(wide_timer_overflow_flag) |->
        !$past(tx_wide_timer_select) && !$past(rx_wide_timer_select))
        else $error("overflow flag set while routed to baud");
    a_mp_stop_high: assert property ($rose(port0_rx_done_flag) && $past(port0_multiproc_enable)
        |-> port0_received_extra_bit)
        else $error("multiproc frame accepted with low stop");
    a_extra_with_done: assert property ($past(rst_n) && $changed(port0_received_extra_bit)
        |-> $rose(port0_rx_done_flag))
        else $error("extra bit changed without acceptance");
    a_buffer_with_done: assert property ($past(rst_n) && !$rose(port0_rx_done_flag)
        |-> $stable(port0_serial_buffer))
        else $error("buffer changed without acceptance");
    c_rx_done: cover property ($rose(port0_rx_done_flag));
    c_tx_done: cover property ($rose(port0_tx_done_flag));
    c_ovf: cover property ($rose(wide_timer_overflow_flag));
endmodule

bind uart_async_mode1_baud uart_async_mode1_baud_chk i_uart_async_mode1_baud_chk (.*);

// [verif/remote_serial_model.sv]
`timescale 1ns/10ps
module remote_serial_model (
    input  wire logic clk,
    input  wire logic from_dut,
    output logic      to_dut
);
    // Idle line sits high, as a pulled-up serial wire does
    initial to_dut = 1'b1;
    task automatic send(input logic [7:0] data, input logic stop_val, input int bitc);
        logic [9:0] frame;
        frame = {stop_val, data, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            to_dut <= frame[i];
            repeat (bitc - 1) @(posedge clk);
        end
        @(posedge clk);
        to_dut <= 1'b1;
    endtask
    task automatic glitch(input int n);
        @(posedge clk);
        to_dut <= 1'b0;
        repeat (n) @(posedge clk);
        to_dut <= 1'b1;
    endtask
    // Returns at mid stop bit; lead counts clocks until the start edge
    task automatic recv(input int bitc, output logic [7:0] data, output logic stop_val, output int lead);
        lead = 0;
        while (from_dut !== 1'b0 && lead < 4000) begin
            @(posedge clk);
            lead++;
        end
        repeat (bitc / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bitc) @(posedge clk);
            data[i] = from_dut;
        end
        repeat (bitc) @(posedge clk);
        stop_val = from_dut;
    endtask
endmodule

// [verif/uart_async_mode1_baud_tb.sv]
`timescale 1ns/10ps
module uart_async_mode1_baud_tb;
    logic       clk, rst_n, t_sel, tx_sel, rx_sel, trig, ovf_clr;
    logic [7:0] rl_a, rl_h, rl_l;
    logic [1:0] dbl, wr, rx_en, mp, txc, rxc;
    logic [7:0] wd [2];
    wire  [1:0] si, so, txf, rxf, xb;
    wire  [7:0] sb0, sb1;
    wire        ovf;
    int         bad_count, checks_done;

    uart_async_mode1_baud i_uart_async_mode1_baud (
        .clk(clk), .rst_n(rst_n), .ce(1'b1), .timer_a_reload_byte(rl_a), .timer_a_clock_select(t_sel),
        .wide_timer_reload_high(rl_h), .wide_timer_reload_low(rl_l), .tx_wide_timer_select(tx_sel),
        .rx_wide_timer_select(rx_sel), .wide_timer_external_trigger(trig), .wide_timer_overflow_clear(ovf_clr),
        .wide_timer_overflow_flag(ovf), .port0_baud_double_bit(dbl[0]), .port1_baud_double_bit(dbl[1]),
        .port0_buffer_write(wr[0]), .port0_write_data(wd[0]), .port1_buffer_write(wr[1]),
        .port1_write_data(wd[1]), .port0_rx_enable(rx_en[0]), .port1_rx_enable(rx_en[1]),
        .port0_multiproc_enable(mp[0]), .port1_multiproc_enable(mp[1]), .port0_tx_done_clear(txc[0]),
        .port0_rx_done_clear(rxc[0]), .port1_tx_done_clear(txc[1]), .port1_rx_done_clear(rxc[1]),
        .port0_serial_in_pin(si[0]), .port1_serial_in_pin(si[1]), .port0_serial_out_pin(so[0]),
        .port1_serial_out_pin(so[1]), .port0_serial_buffer(sb0), .port1_serial_buffer(sb1),
        .port0_received_extra_bit(xb[0]), .port1_received_extra_bit(xb[1]), .port0_tx_done_flag(txf[0]),
        .port1_tx_done_flag(txf[1]), .port0_rx_done_flag(rxf[0]), .port1_rx_done_flag(rxf[1]));
    remote_serial_model i_remote_p0 (.clk(clk), .from_dut(so[0]), .to_dut(si[0]));
    remote_serial_model i_remote_p1 (.clk(clk), .from_dut(so[1]), .to_dut(si[1]));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ----------------
    // Checking and closing
    // ----------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ----------------
    // Port operations
    // ----------------
    task automatic clr(input int p);
        @(posedge clk);
        txc[p] <= 1'b1;
        rxc[p] <= 1'b1;
        @(posedge clk);
        txc[p] <= 1'b0;
        rxc[p] <= 1'b0;
    endtask
    task automatic tx_test(input int p, input logic [7:0] d, input int bitc);
        logic [7:0] got;
        logic       stp;
        int         lead;
        @(posedge clk);
        wr[p] <= 1'b1;
        wd[p] <= d;
        @(posedge clk);
        wr[p] <= 1'b0;
        if (p == 0) i_remote_p0.recv(bitc, got, stp, lead);
        else i_remote_p1.recv(bitc, got, stp, lead);
        check("tx byte", got, d);
        check("tx stop", stp, 1'b1);
        check("tx start delay", lead <= bitc + 4, 1'b1);
        check("tx done early", txf[p], 1'b0);
        repeat (bitc / 2 + 4) @(posedge clk);
        check("tx done", txf[p], 1'b1);
        clr(p);
    endtask
    task automatic rx_test(input int p, input logic [7:0] d, input logic stp, input int bitc,
                           input logic ef, input logic [7:0] eb, input logic ex);
        if (p == 0) i_remote_p0.send(d, stp, bitc);
        else i_remote_p1.send(d, stp, bitc);
        repeat (8) @(posedge clk);
        check("rx flag", rxf[p], ef);
        check("rx byte", p ? sb1 : sb0, eb);
        check("rx extra", xb[p], ex);
    endtask
    // ----------------
    // Sequence
    // ----------------
    initial begin
        bad_count = 0;
        checks_done = 0;
        rst_n = 1'b0; t_sel = 1'b1; tx_sel = 1'b0; rx_sel = 1'b0; trig = 1'b1; ovf_clr = 1'b0;
        rl_a = 8'hff; rl_h = 8'hff; rl_l = 8'hff; dbl = 2'h3; wr = 2'h0; rx_en = 2'h0; mp = 2'h0;
        txc = 2'h0; rxc = 2'h0; wd[0] = 8'h00; wd[1] = 8'h00;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check("idle out", so, 2'h3);
        check("reset buffer", sb0, 8'h00);
        // Trigger edge loads all ones; timer A climbs 1024 clocks before rolling
        trig <= 1'b0;
        @(posedge clk);
        trig <= 1'b1;
        repeat (1100) @(posedge clk);
        // Four clocks per rollover, sixteen rollovers per bit
        tx_test(0, 8'ha5, 64);
        tx_test(1, 8'h3c, 64);
        dbl <= 2'h1;
        tx_test(1, 8'h96, 128);
        dbl <= 2'h3;
        t_sel <= 1'b0;
        tx_test(0, 8'h0f, 192);
        t_sel <= 1'b1;
        tx_sel <= 1'b1;
        tx_test(0, 8'hc3, 32);
        tx_test(1, 8'h5a, 64);
        // Trigger toggles too, to show it is ignored while routed
        repeat (4) @(posedge clk);
        ovf_clr <= 1'b1;
        trig <= 1'b0;
        @(posedge clk);
        ovf_clr <= 1'b0;
        trig <= 1'b1;
        repeat (200) @(posedge clk);
        check("ovf routed", ovf, 1'b0);
        tx_sel <= 1'b0;
        repeat (200) @(posedge clk);
        check("ovf free", ovf, 1'b1);
        rx_en <= 2'h3;
        rx_test(0, 8'h5a, 1'b1, 64, 1'b1, 8'h5a, 1'b1);
        rx_test(0, 8'h11, 1'b1, 64, 1'b1, 8'h5a, 1'b1);
        clr(0);
        mp <= 2'h1;
        rx_test(0, 8'h22, 1'b0, 64, 1'b0, 8'h5a, 1'b1);
        i_remote_p0.glitch(8);
        repeat (200) @(posedge clk);
        check("glitch flag", rxf[0], 1'b0);
        rx_test(0, 8'h44, 1'b1, 64, 1'b1, 8'h44, 1'b1);
        clr(0);
        mp <= 2'h0;
        rx_sel <= 1'b1;
        rx_test(0, 8'h81, 1'b0, 32, 1'b1, 8'h81, 1'b0);
        rx_en <= 2'h1;
        rx_test(1, 8'h77, 1'b1, 64, 1'b0, 8'h00, 1'b0);
        rx_en <= 2'h3;
        rx_test(1, 8'h77, 1'b1, 64, 1'b1, 8'h77, 1'b1);
        end_sim();
    end
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        end_sim();
    end
endmodule
